// *** core/timer_ppg_oneshot_capture.sv ***
`timescale 1ns/1ps
module timer_ppg_oneshot_capture
    import tmr_pkg::*;
(
    input  wire logic        hclk,                   // System and count clock
    input  wire logic        hresetn,                // Async reset, active low
    input  wire logic        hsel,                   // Slave select
    input  wire logic [31:0] haddr,                  // Byte address
    input  wire logic [1:0]  htrans,                 // Transfer type
    input  wire logic        hwrite,                 // Write when high
    input  wire logic [2:0]  hsize,                  // Word only
    input  wire logic [31:0] hwdata,                 // Write data
    input  wire logic        hready,                 // Bus ready in
    output logic [31:0]      hrdata,                 // Read data
    output logic             hreadyout,              // Slave ready
    output logic             hresp,                  // Always OKAY
    input  wire logic        trigger_capture_pin_a,  // Trigger, event or capture A pin
    input  wire logic        capture_pin_b,          // Capture B pin
    output logic             timer_out,              // Timer output pin
    output logic             irq                     // Level interrupt
);
    typedef struct packed {
        logic [1:0]  op_mode;      // op_mode_bit_hi, op_mode_bit_lo
        logic        inv_en;       // duty_match_invert_enable
        logic        os_en;        // One-shot select inside pulse mode
        logic        soft_trig;    // oneshot_soft_trigger pulse
        logic [15:0] period;       // period_compare_reg
        logic [15:0] duty;         // duty_compare_reg
        logic [15:0] cnt;          // timer_count_reg
        logic        tout;
        logic        busy;         // One-shot pulse in progress
        logic [3:0]  status;       // Bit 1 is duty_match_irq_flag
        logic [3:0]  mask;         // Bit 1 is duty_match_irq_mask
        logic        irq;
        logic        ap_valid;
        logic        ap_write;
        logic [7:0]  ap_addr;
        logic        hready;
        logic [31:0] hrdata;
        logic        hresp;
    } state_type;

    state_type   st_r;
    state_type   st_nxt;
    logic        rise_a;
    logic        rise_b;
    logic        pmatch;
    logic        dmatch;
    logic        cap_a;
    logic        cap_b;
    logic [3:0]  set_ev;
    logic [3:0]  w1c;
    logic [31:0] rd;

    // ****************************************
    // Pin synchronisers
    // ****************************************
    pin_edge_sync #(.RST_LEVEL(1'b0)) u_sync_a (
        .hclk    (hclk),
        .hresetn (hresetn),
        .pin     (trigger_capture_pin_a),
        .rise    (rise_a)
    );

    pin_edge_sync #(.RST_LEVEL(1'b0)) u_sync_b (
        .hclk    (hclk),
        .hresetn (hresetn),
        .pin     (capture_pin_b),
        .rise    (rise_b)
    );

    assign pmatch = (st_r.cnt == st_r.period);
    assign dmatch = (st_r.cnt == st_r.duty);
    assign cap_a  = (st_r.op_mode == MODE_CAPT) && rise_a;
    assign cap_b  = (st_r.op_mode == MODE_CAPT) && rise_b;

    // ****************************************
    // Next state: counter, then bus, then flags
    // ****************************************
    always_comb begin
        st_nxt           = st_r;
        st_nxt.soft_trig = 1'b0;
        set_ev           = 4'h0;
        w1c              = 4'h0;
        rd               = WORD_ZERO;
        // Counter and output per operating mode
        case (st_r.op_mode)
            MODE_PPG: begin
                if (st_r.os_en) begin
                    if (st_r.busy) begin
                        st_nxt.cnt = st_r.cnt + CNT_ONE;
                        if (dmatch) begin
                            st_nxt.tout      = 1'b1;
                            set_ev[IRQ_DUTY] = 1'b1;
                        end
                        if (pmatch) begin
                            st_nxt.cnt         = CNT_ZERO;
                            st_nxt.tout        = 1'b0;
                            st_nxt.busy        = 1'b0;
                            set_ev[IRQ_PERIOD] = 1'b1;
                        end
                    end else begin
                        // Triggers during a pulse are ignored by the busy gate
                        st_nxt.cnt  = CNT_ZERO;
                        st_nxt.tout = 1'b0;
                        if (st_r.soft_trig || rise_a) begin
                            st_nxt.busy = 1'b1;
                        end
                    end
                end else begin
                    if (pmatch) begin
                        st_nxt.cnt         = CNT_ZERO;
                        st_nxt.tout        = 1'b1;
                        set_ev[IRQ_PERIOD] = 1'b1;
                    end else begin
                        st_nxt.cnt = st_r.cnt + CNT_ONE;
                    end
                    if (dmatch) begin
                        set_ev[IRQ_DUTY] = 1'b1;
                        // No inversion while disabled, so a duty rewrite is glitch free
                        if (st_r.inv_en && !pmatch) begin
                            st_nxt.tout = ~st_r.tout;
                        end
                    end
                end
            end
            MODE_CAPT: begin
                st_nxt.cnt = st_r.cnt + CNT_ONE;
                if (cap_a) begin
                    st_nxt.period     = st_r.cnt;
                    set_ev[IRQ_CAP_A] = 1'b1;
                end
                if (cap_b) begin
                    st_nxt.duty       = st_r.cnt;
                    set_ev[IRQ_CAP_B] = 1'b1;
                end
            end
            MODE_EVENT: begin
                if (rise_a) begin
                    if (pmatch) begin
                        st_nxt.cnt         = CNT_ZERO;
                        set_ev[IRQ_PERIOD] = 1'b1;
                    end else begin
                        st_nxt.cnt = st_r.cnt + CNT_ONE;
                    end
                end
            end
            default: begin
                st_nxt.cnt  = CNT_ZERO;
                st_nxt.tout = 1'b0;
                st_nxt.busy = 1'b0;
            end
        endcase

        // Data phase of a write; captures win over software on the compares
        if (st_r.ap_valid && st_r.ap_write) begin
            case (st_r.ap_addr)
                OFS_CTRL: begin
                    st_nxt.inv_en    = hwdata[CTRL_INV_EN];
                    st_nxt.os_en     = hwdata[CTRL_OS_EN];
                    st_nxt.soft_trig = hwdata[CTRL_SOFT_TRG];
                    st_nxt.op_mode   = hwdata[CTRL_MODE_HI:CTRL_MODE_LO];
                    if (hwdata[CTRL_MODE_HI:CTRL_MODE_LO] != st_r.op_mode) begin
                        // Restart from zero on any mode change
                        st_nxt.cnt  = CNT_ZERO;
                        st_nxt.busy = 1'b0;
                        st_nxt.tout = (hwdata[CTRL_MODE_HI:CTRL_MODE_LO] == MODE_PPG)
                                      && !hwdata[CTRL_OS_EN];
                    end
                end
                OFS_PERIOD: begin
                    if (!cap_a) begin
                        st_nxt.period = hwdata[15:0];
                    end
                end
                OFS_DUTY: begin
                    if (!cap_b) begin
                        st_nxt.duty = hwdata[15:0];
                    end
                end
                OFS_STATUS: w1c = hwdata[3:0];
                OFS_MASK:   st_nxt.mask = hwdata[3:0];
                default:    st_nxt.mask = st_r.mask;
            endcase
        end

        // A set in the same cycle as its clear is kept
        st_nxt.status = (st_r.status & ~w1c) | set_ev;
        st_nxt.irq    = |(st_nxt.status & ~st_nxt.mask);

        // Read mux sampled one cycle late so a preceding write is visible
        case (st_r.ap_addr)
            OFS_CTRL:   rd = {28'h000_0000, st_r.os_en, st_r.inv_en, st_r.op_mode};
            OFS_PERIOD: rd = {16'h0000, st_r.period};
            OFS_DUTY:   rd = {16'h0000, st_r.duty};
            OFS_COUNT:  rd = {16'h0000, st_r.cnt};
            OFS_STATUS: rd = {28'h000_0000, st_r.status};
            OFS_MASK:   rd = {28'h000_0000, st_r.mask};
            OFS_STATE:  rd = {30'h0000_0000, st_r.busy, st_r.tout};
            default:    rd = WORD_ZERO;
        endcase

        // Bus phases: reads take one wait state, writes none
        st_nxt.hresp = 1'b0;
        if (st_r.ap_valid) begin
            st_nxt.ap_valid = 1'b0;
            if (!st_r.ap_write) begin
                st_nxt.hrdata = rd;
                st_nxt.hready = 1'b1;
            end
        end
        if (hsel && hready && htrans[1] && st_r.hready) begin
            st_nxt.ap_valid = 1'b1;
            st_nxt.ap_write = hwrite;
            st_nxt.ap_addr  = {haddr[7:2], 2'h0};
            st_nxt.hready   = hwrite;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_r        <= '0;
            st_r.period <= CMP_RST;
            st_r.duty   <= CMP_RST;
            st_r.mask   <= MASK_RST;
            st_r.hready <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign hrdata    = st_r.hrdata;
    assign hreadyout = st_r.hready;
    assign hresp     = st_r.hresp;
    assign timer_out = st_r.tout;
    assign irq       = st_r.irq;

    // ****************************************
    // Checks
    // ****************************************
    wire ppg_run = (st_r.op_mode == MODE_PPG) && !st_r.os_en;
    wire no_wr   = !(st_r.ap_valid && st_r.ap_write);

    property p_ppg_wrap;
        @(posedge hclk) disable iff (!hresetn)
        ppg_run && pmatch && no_wr |=> (st_r.cnt == CNT_ZERO) && timer_out;
    endproperty
    a_ppg_wrap: assert property (p_ppg_wrap) else $error("period match no wrap");

    property p_no_toggle;
        @(posedge hclk) disable iff (!hresetn)
        ppg_run && !st_r.inv_en && dmatch && !pmatch && no_wr |=> $stable(timer_out);
    endproperty
    a_no_toggle: assert property (p_no_toggle) else $error("toggle while disabled");

    property p_duty_toggle;
        @(posedge hclk) disable iff (!hresetn)
        ppg_run && st_r.inv_en && dmatch && !pmatch && no_wr |=> timer_out != $past(timer_out);
    endproperty
    a_duty_toggle: assert property (p_duty_toggle) else $error("duty match no toggle");

    property p_stop;
        @(posedge hclk) disable iff (!hresetn)
        (st_r.op_mode == MODE_STOP) && no_wr |=> (st_r.cnt == CNT_ZERO) && !timer_out;
    endproperty
    a_stop: assert property (p_stop) else $error("stopped timer moved");

    property p_count;
        @(posedge hclk) disable iff (!hresetn)
        ppg_run && !pmatch && no_wr |=> st_r.cnt == $past(st_r.cnt) + CNT_ONE;
    endproperty
    a_count: assert property (p_count) else $error("running counter stuck");

    property p_event;
        @(posedge hclk) disable iff (!hresetn)
        (st_r.op_mode == MODE_EVENT) && rise_a && !pmatch && no_wr
            |=> st_r.cnt == $past(st_r.cnt) + CNT_ONE;
    endproperty
    a_event: assert property (p_event) else $error("event not counted");

    property p_os_pin;
        @(posedge hclk) disable iff (!hresetn)
        (st_r.op_mode == MODE_PPG) && st_r.os_en && !st_r.busy && rise_a && no_wr
            |=> st_r.busy ##1 st_r.cnt == CNT_ONE;
    endproperty
    a_os_pin: assert property (p_os_pin) else $error("pin edge no one-shot");

    property p_cap_b;
        @(posedge hclk) disable iff (!hresetn)
        cap_b |=> st_r.duty == $past(st_r.cnt) && st_r.status[IRQ_CAP_B];
    endproperty
    a_cap_b: assert property (p_cap_b) else $error("capture b lost");

endmodule : timer_ppg_oneshot_capture

// *** core/tmr_pkg.sv ***
package tmr_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0]  OFS_CTRL    = 8'h00;
    localparam logic [7:0]  OFS_PERIOD  = 8'h04;
    localparam logic [7:0]  OFS_DUTY    = 8'h08;
    localparam logic [7:0]  OFS_COUNT   = 8'h0c;
    localparam logic [7:0]  OFS_STATUS  = 8'h10;
    localparam logic [7:0]  OFS_MASK    = 8'h14;
    localparam logic [7:0]  OFS_STATE   = 8'h18;

    // ****************************************
    // Fields and reset values
    // ****************************************
    localparam int          CTRL_MODE_LO  = 0;
    localparam int          CTRL_MODE_HI  = 1;
    localparam int          CTRL_INV_EN   = 2;
    localparam int          CTRL_OS_EN    = 3;
    localparam int          CTRL_SOFT_TRG = 4;
    localparam int          IRQ_PERIOD    = 0;
    localparam int          IRQ_DUTY      = 1;
    localparam int          IRQ_CAP_A     = 2;
    localparam int          IRQ_CAP_B     = 3;
    localparam logic [3:0]  MASK_RST      = 4'hf;
    localparam logic [15:0] CNT_ZERO      = 16'h0000;
    localparam logic [15:0] CNT_ONE       = 16'h0001;
    localparam logic [15:0] CMP_RST       = 16'hffff;
    localparam logic [31:0] WORD_ZERO     = 32'h0000_0000;

    // ****************************************
    // Operating modes
    // ****************************************
    localparam logic [1:0]  MODE_STOP   = 2'h0;
    localparam logic [1:0]  MODE_PPG    = 2'h1;
    localparam logic [1:0]  MODE_CAPT   = 2'h2;
    localparam logic [1:0]  MODE_EVENT  = 2'h3;

endpackage : tmr_pkg

// *** core/pin_edge_sync.sv ***
`timescale 1ns/1ps
// ****************************************
// Two-flop pin synchroniser with rise detect
// ****************************************
module pin_edge_sync #(
    parameter logic RST_LEVEL = 1'b0        // Level assumed before reset release
) (
    input  wire logic hclk,                 // System clock
    input  wire logic hresetn,              // Async reset, active low
    input  wire logic pin,                  // Raw asynchronous pin
    output logic      rise                  // One-cycle pulse on rising edge
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
    } sync_type;

    sync_type st_r;
    sync_type st_nxt;

    // Shift chain; only s2 and s3 feed the edge detect, s1 may be metastable
    always_comb begin
        st_nxt    = st_r;
        st_nxt.s1 = pin;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_r <= {RST_LEVEL, RST_LEVEL, RST_LEVEL};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rise = st_r.s2 & ~st_r.s3;

endmodule : pin_edge_sync

// *** tb/tb.sv ***
`timescale 1ns/1ps
module tb;
    import tmr_pkg::*;

    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = WORD_ZERO;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = WORD_ZERO;
    logic        hready;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        pin_a = 1'b0;
    logic        pin_b = 1'b0;
    logic        timer_out;
    logic        irq;
    int          n_fail = 0;
    int          checked = 0;
    logic [31:0] rd;
    logic [31:0] cap_a;
    int          hi;
    int          per;

    // ****************************************
    // Clock, single slave so hready follows it
    // ****************************************
    always #5 hclk = ~hclk;
    assign hready = hreadyout;

    timer_ppg_oneshot_capture DUT (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .trigger_capture_pin_a(pin_a), .capture_pin_b(pin_b),
        .timer_out(timer_out), .irq(irq)
    );

    // ****************************************
    // Bus and compare tasks
    // ****************************************
    // Address phase held until hready, then data phase held until hready
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h00_0000, a};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
        hsel <= 1'b0;
    endtask : bus

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
        end
    endtask : chk_word

    task automatic chk_bit(input logic got, input logic exp);
        chk_word({31'h0, got}, {31'h0, exp});
    endtask : chk_bit

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, WORD_ZERO);
        chk_word(rd, exp);
    endtask : rd_chk

    // Counts high cycles of timer_out from its next rise, then high plus the low cycles after as the period
    task automatic measure();
        int n;
        n = 0;
        while (timer_out !== 1'b0 && n < 200) begin @(posedge hclk); n++; end
        while (timer_out !== 1'b1 && n < 400) begin @(posedge hclk); n++; end
        hi = 0;
        while (timer_out === 1'b1 && hi < 200) begin @(posedge hclk); hi++; end
        per = hi;
        while (timer_out === 1'b0 && per < 200) begin @(posedge hclk); per++; end
    endtask : measure

    task automatic pulse_a(input int len);
        pin_a <= 1'b1;
        repeat (len) @(posedge hclk);
        pin_a <= 1'b0;
        repeat (len) @(posedge hclk);
    endtask : pulse_a

    // ****************************************
    // Scenarios
    // ****************************************
    // Reset values, an unmapped offset and quiet outputs
    task automatic t_reset();
        rd_chk(OFS_CTRL, WORD_ZERO);
        rd_chk(OFS_PERIOD, 32'h0000_ffff);
        rd_chk(OFS_DUTY, 32'h0000_ffff);
        rd_chk(OFS_COUNT, WORD_ZERO);
        rd_chk(OFS_STATUS, WORD_ZERO);
        rd_chk(OFS_MASK, 32'h0000_000f);
        rd_chk(8'h20, WORD_ZERO);
        chk_bit(irq, 1'b0);
        chk_bit(hresp, 1'b0);
    endtask : t_reset

    // Pulse shape, duty interrupt, then inversion off and the rewrite sequence
    task automatic t_ppg();
        int n;
        bus(1'b1, OFS_PERIOD, 32'h0000_0007);
        bus(1'b1, OFS_DUTY, 32'h0000_0002);
        bus(1'b1, OFS_CTRL, 32'h0000_0005);
        measure();
        chk_word(hi, 3);
        chk_word(per, 8);
        bus(1'b1, OFS_MASK, 32'h0000_000d);
        repeat (12) @(posedge hclk);
        chk_bit(irq, 1'b1);
        bus(1'b1, OFS_MASK, 32'h0000_000f);
        repeat (3) @(posedge hclk);
        chk_bit(irq, 1'b0);
        bus(1'b1, OFS_CTRL, 32'h0000_0001);
        bus(1'b1, OFS_DUTY, 32'h0000_0004);
        // Let the current low part run out; the next period match sets the output
        repeat (8) @(posedge hclk);
        n = 0;
        repeat (20) begin @(posedge hclk); if (timer_out !== 1'b1) n++; end
        chk_word(n, 0);
        bus(1'b1, OFS_CTRL, 32'h0000_0005);
        measure();
        chk_word(hi, 5);
        chk_word(per, 8);
        bus(1'b1, OFS_CTRL, WORD_ZERO);
        bus(1'b1, OFS_STATUS, 32'h0000_000f);
        rd_chk(OFS_STATUS, WORD_ZERO);
        bus(1'b1, OFS_MASK, 32'h0000_000d);
        repeat (3) @(posedge hclk);
        chk_bit(irq, 1'b0);
        chk_bit(timer_out, 1'b0);
        bus(1'b1, OFS_MASK, 32'h0000_000f);
    endtask : t_ppg

    // Two capture pins load their own registers seven counts apart
    task automatic t_capture();
        bus(1'b1, OFS_CTRL, 32'h0000_0002);
        pin_a <= 1'b1;
        repeat (7) @(posedge hclk);
        pin_b <= 1'b1;
        repeat (6) @(posedge hclk);
        pin_a <= 1'b0;
        pin_b <= 1'b0;
        bus(1'b0, OFS_PERIOD, WORD_ZERO);
        cap_a = rd;
        bus(1'b0, OFS_DUTY, WORD_ZERO);
        chk_word(rd - cap_a, 32'h0000_0007);
        rd_chk(OFS_STATUS, 32'h0000_000c);
        bus(1'b1, OFS_STATUS, 32'h0000_000f);
    endtask : t_capture

    // Counter register holds the number of pin events
    task automatic t_event();
        bus(1'b1, OFS_CTRL, WORD_ZERO);
        bus(1'b1, OFS_PERIOD, 32'h0000_ffff);
        bus(1'b1, OFS_CTRL, 32'h0000_0003);
        rd_chk(OFS_COUNT, WORD_ZERO);
        repeat (5) pulse_a(3);
        repeat (4) @(posedge hclk);
        rd_chk(OFS_COUNT, 32'h0000_0005);
    endtask : t_event

    // Pin trigger and soft trigger each give one pulse of period-duty cycles
    task automatic t_oneshot();
        bus(1'b1, OFS_CTRL, WORD_ZERO);
        bus(1'b1, OFS_PERIOD, 32'h0000_0006);
        bus(1'b1, OFS_DUTY, 32'h0000_0002);
        bus(1'b1, OFS_CTRL, 32'h0000_0009);
        pin_a <= 1'b1;
        measure();
        pin_a <= 1'b0;
        chk_word(hi, 4);
        rd_chk(OFS_STATE, WORD_ZERO);
        bus(1'b1, OFS_CTRL, 32'h0000_0019);
        measure();
        chk_word(hi, 4);
        rd_chk(OFS_CTRL, 32'h0000_0009);
    endtask : t_oneshot

    // ****************************************
    // Run control
    // ****************************************
    task automatic stop_test();
        $display("checked=%0d n_fail=%0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : stop_test

    // Whole run needs well under 3000 cycles
    initial begin
        repeat (20000) @(posedge hclk);
        n_fail++;
        stop_test();
    end

    initial begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset();
        t_ppg();
        t_capture();
        t_event();
        t_oneshot();
        stop_test();
    end

endmodule : tb
